// File: verif/dbp_bridge_test.sv
// self-checking bench for the diagnostic bridge pin logic
`timescale 1ns/100ps
module dbp_bridge_test;
    import dbp_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [1:0]  bresp, rresp, r;
    logic        clr_n = 1'b1, mem_s = 1'b1, baud_s = 1'b1, lf_s = 1'b0, dom = 1'b0;
    logic        vpw, kl_n, pw_n, sup, bp, bm, osc;
    int          checks = 0, fail_count = 0;

    ////////////////////////////////////////
    // design and far-side model
    dbp_bridge DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .master_clear_in_n(clr_n), .memory_strap_in(mem_s),
        .baud_strap_in(baud_s), .line_ending_strap_in(lf_s), .variable_pulse_rx_in(vpw), .kline_rx_in_n(kl_n),
        .pulse_width_rx_in_n(pw_n), .bus_supply_select_out(sup), .bus_plus_drive_out(bp),
        .bus_minus_drive_out(bm), .osc_enable_out(osc));
    dbp_bus_model PARTNER (.plus_drive(bp), .minus_drive(bm), .remote_dom(dom), .vpw_rx(vpw),
        .kline_rx_n(kl_n), .pwm_rx_n(pw_n));

    ////////////////////////////////////////
    // clock and watchdog
    initial
    begin
        forever #25 aclk = ~aclk;
    end
    initial
    begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        complete_run();
    end

    ////////////////////////////////////////
    // bus tasks, comparison and verdict
    task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] eresp);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, eresp});
        rready <= 1'b0;
    endtask : rchk
    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////
    // test sequence
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        rchk(ADDR_STATUS, 32'h00010301, RESP_OKAY);
        rchk(ADDR_BAUD_RATE, 32'h00009600, RESP_OKAY);
        wr(ADDR_CTRL, 32'h00000006, r);
        rchk(ADDR_STATUS, 32'h00010302, RESP_OKAY);
        wr(ADDR_CTRL, 32'h00000009, r);
        rchk(ADDR_STATUS, 32'h00010301, RESP_OKAY);
        wr(5'h14, 32'h0000FFFF, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rchk(5'h14, 32'h00000000, RESP_SLVERR);
        // every protocol, with and without supply polarity inversion
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_PARAM, 32'(i / 4), r);
            wr(ADDR_CTRL, 32'h00001000 | 32'((i % 4) << 8), r);
            chk({29'h0, sup, bp, bm}, {29'h0, (i % 4 == 1) != (i >= 4), 1'b1, i % 4 == 2});
        end
        // receive polarity from own drive, then from a remote node
        wr(ADDR_PARAM, 32'h00000000, r);
        wr(ADDR_CTRL, 32'h00001200, r);
        rchk(ADDR_STATUS, 32'h00010329, RESP_OKAY);
        dom <= 1'b1;
        // let the pin change pass the synchroniser before the status is taken
        repeat (2) @(posedge aclk);
        rchk(ADDR_STATUS, 32'h00010339, RESP_OKAY);
        dom <= 1'b0;
        // standby stops oscillator and drives
        wr(ADDR_CTRL, 32'h00011000, r);
        chk({30'h0, bp, osc}, 32'h00000000);
        wr(ADDR_CTRL, 32'h00001000, r);
        chk({30'h0, bp, osc}, 32'h00000003);
        // short clear is ignored, long clear reloads the straps
        wr(ADDR_BAUD_PARAM, 32'h0001C200, r);
        mem_s <= 1'b0;
        lf_s  <= 1'b1;
        clr_n <= 1'b0;
        repeat (20) @(posedge aclk);
        clr_n <= 1'b1;
        repeat (6) @(posedge aclk);
        rchk(ADDR_BAUD_RATE, 32'h00009600, RESP_OKAY);
        chk({31'h0, bp}, 32'h00000001);
        clr_n <= 1'b0;
        repeat (60) @(posedge aclk);
        clr_n <= 1'b1;
        repeat (12) @(posedge aclk);
        rchk(ADDR_STATUS, 32'h00010602, RESP_OKAY);
        rchk(ADDR_BAUD_RATE, 32'h0001C200, RESP_OKAY);
        // low baud strap through a full reset
        baud_s  <= 1'b0;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        rchk(ADDR_BAUD_RATE, 32'h00002580, RESP_OKAY);
        complete_run();
    end
endmodule : dbp_bridge_test

// File: verif/dbp_bus_model.sv
// line driver and receiver model for the vehicle diagnostic buses
`timescale 1ns/100ps
module dbp_bus_model
    import dbp_pkg::*;
(
    input  wire logic plus_drive,
    input  wire logic minus_drive,
    input  wire logic remote_dom,
    output logic      vpw_rx,
    output logic      kline_rx_n,
    output logic      pwm_rx_n
);
    ////////////////////////////////////////
    // VPW and pulse-width lines are dominant while our node or a remote node drives them, the K-line only from a remote node
    assign vpw_rx     = plus_drive | remote_dom;
    assign kline_rx_n = ~remote_dom;
    assign pwm_rx_n   = ~(minus_drive | remote_dom);
endmodule : dbp_bus_model

// File: verilog/dbp_bridge.sv
// diagnostic bus bridge pin logic: clear, straps, bus drives, receive polarity, oscillator
//
// Behaviour
// [RL1] clear held low over 2us resets device
// [RL2] memory strap sets default memory option
// [RL3] memory on/off commands override the strap
// [RL4] baud strap high: 38400 or programmed rate
// [RL5] baud strap low: 9600 bits per second
// [RL6] line strap high: end lines CR LF
// [RL7] line strap low: end lines CR only
// [RL8] linefeed on/off commands override the strap
// [RL9] supply select high for VPW, invertible
// [RL10] bus plus drive high asserts positive line
// [RL11] bus minus drive only for pulse-width protocol
// [RL12] VPW receive input is active high
// [RL13] K-line receive input is active low
// [RL14] pulse-width receive input is active low
// [RL15] oscillator stops in standby, restarts after
// [RL16] synchronise pins, latch straps after reset
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module dbp_bridge
    import dbp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // pins
    input  wire logic        master_clear_in_n,
    input  wire logic        memory_strap_in,
    input  wire logic        baud_strap_in,
    input  wire logic        line_ending_strap_in,
    input  wire logic        variable_pulse_rx_in,
    input  wire logic        kline_rx_in_n,
    input  wire logic        pulse_width_rx_in_n,
    output logic             bus_supply_select_out,
    output logic             bus_plus_drive_out,
    output logic             bus_minus_drive_out,
    output logic             osc_enable_out
);

    dbp_state_t             st_reg;
    dbp_state_t             st_next;
    logic [PIN_COUNT-1:0]   pins_raw;
    logic [PIN_COUNT-1:0]   pins_s;
    logic                   clear_hold;
    logic                   wr_fire;
    logic [3:0]             cmd;
    logic                   vpw_active;
    logic                   kline_active;
    logic                   pwm_active;
    logic [31:0]            status_word;
    logic [31:0]            ctrl_word;
    logic [4:0]             rd_addr;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    assign pins_raw = {pulse_width_rx_in_n, kline_rx_in_n, variable_pulse_rx_in,
                       line_ending_strap_in, baud_strap_in, memory_strap_in, master_clear_in_n};

    dbp_sync u_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pins      (pins_raw),  // RL16
        .pins_sync (pins_s)
    );

    // receive polarity: active levels seen on the bus
    assign vpw_active   = pins_s[PIN_VPW];    // RL12
    assign kline_active = !pins_s[PIN_KLINE]; // RL13
    assign pwm_active   = !pins_s[PIN_PWM];   // RL14

    // clear held past the minimum low time keeps the core in reset
    assign clear_hold = !pins_s[PIN_CLEAR] && (st_reg.clear_cnt == CLEAR_CNT_MAX); // RL1

    // readback words
    assign ctrl_word   = {15'h0000, st_reg.cfg.standby, 3'h0, st_reg.cfg.bus_plus_req, 2'h0,
                          st_reg.cfg.proto, 8'h00};
    assign status_word = {15'h0000, (st_reg.phase == PH_RUN), 5'h00, st_reg.cfg.straps, 2'h0,
                          pwm_active, kline_active, vpw_active, st_reg.cfg.standby,
                          st_reg.cfg.crlf, st_reg.cfg.mem_en};
    assign rd_addr     = {araddr[4:2], 2'b00};
    assign wr_fire     = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        st_next = st_reg;
        cmd     = 4'h0;

        // clear low-time counter, saturating
        if (pins_s[PIN_CLEAR])
            st_next.clear_cnt = 8'h00;
        else if (st_reg.clear_cnt != CLEAR_CNT_MAX)
            st_next.clear_cnt = st_reg.clear_cnt + 8'h01; // RL1

        // write address and data, in either order
        if (awvalid && st_reg.awready)
        begin
            st_next.aw_have  = 1'b1;
            st_next.awaddr_q = {awaddr[4:2], 2'b00};
        end
        if (wvalid && st_reg.wready)
        begin
            st_next.w_have  = 1'b1;
            st_next.wdata_q = wdata;
            st_next.wstrb_q = wstrb;
        end
        if (st_reg.bvalid && bready)
            st_next.bvalid = 1'b0;

        // register write
        if (wr_fire)
        begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = RESP_OKAY;
            case (st_reg.awaddr_q)
                ADDR_CTRL:
                begin
                    if (st_reg.wstrb_q[0])
                        cmd = st_reg.wdata_q[CTRL_LF_OFF:CTRL_MEM_ON];
                    if (st_reg.wstrb_q[1])
                    begin
                        st_next.cfg.proto        = dbp_proto_t'(st_reg.wdata_q[CTRL_PROTO +: 2]);
                        st_next.cfg.bus_plus_req = st_reg.wdata_q[CTRL_BUS_PLS];
                    end
                    if (st_reg.wstrb_q[2])
                        st_next.cfg.standby = st_reg.wdata_q[CTRL_STANDBY];
                end
                ADDR_PARAM:
                begin
                    if (st_reg.wstrb_q[0])
                        st_next.cfg.supply_pol = st_reg.wdata_q[0];
                end
                ADDR_BAUD_PARAM:
                    st_next.cfg.baud_param = dbp_merge(st_reg.cfg.baud_param, st_reg.wdata_q, st_reg.wstrb_q);
                ADDR_STATUS,
                ADDR_BAUD_RATE:
                    st_next.bresp = RESP_OKAY;
                default:
                    st_next.bresp = RESP_SLVERR;
            endcase
        end
        st_next.awready = !st_next.aw_have;
        st_next.wready  = !st_next.w_have;

        // register read
        if (arvalid && st_reg.arready)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            case (rd_addr)
                ADDR_CTRL:       st_next.rdata = ctrl_word;
                ADDR_PARAM:      st_next.rdata = {31'h00000000, st_reg.cfg.supply_pol};
                ADDR_BAUD_PARAM: st_next.rdata = st_reg.cfg.baud_param;
                ADDR_STATUS:     st_next.rdata = status_word;
                ADDR_BAUD_RATE:  st_next.rdata = st_reg.cfg.baud_rate;
                default:
                begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (st_reg.rvalid && rready)
            st_next.rvalid = 1'b0;
        st_next.arready = !st_next.rvalid;

        // strap loading sequence
        case (st_reg.phase)
            PH_WAIT:
            begin
                // let the synchroniser fill with real pin levels
                if (st_reg.wait_cnt == 2'h0)
                    st_next.phase = PH_LOAD;
                else
                    st_next.wait_cnt = st_reg.wait_cnt - 2'h1;
            end
            PH_LOAD:
            begin
                st_next.cfg.straps = {pins_s[PIN_LF], pins_s[PIN_BAUD], pins_s[PIN_MEM]}; // RL16
                st_next.cfg.mem_en = pins_s[PIN_MEM];                                    // RL2
                st_next.cfg.crlf   = pins_s[PIN_LF];                                     // RL6 RL7
                if (!pins_s[PIN_BAUD])
                    st_next.cfg.baud_rate = BAUD_LOW;                                    // RL5
                else if (st_reg.cfg.baud_param != 32'h00000000)
                    st_next.cfg.baud_rate = st_reg.cfg.baud_param;                       // RL4
                else
                    st_next.cfg.baud_rate = BAUD_HIGH;                                   // RL4
                st_next.phase = PH_RUN;
            end
            PH_RUN:
            begin
                // commands override strap defaults, on wins a same-write clash
                if (cmd[CTRL_MEM_ON])
                    st_next.cfg.mem_en = 1'b1;  // RL3
                else if (cmd[CTRL_MEM_OFF])
                    st_next.cfg.mem_en = 1'b0;  // RL3
                if (cmd[CTRL_LF_ON])
                    st_next.cfg.crlf = 1'b1;    // RL8
                else if (cmd[CTRL_LF_OFF])
                    st_next.cfg.crlf = 1'b0;    // RL8
            end
            default:
            begin
                st_next.phase    = PH_WAIT;
                st_next.wait_cnt = STRAP_WAIT;
            end
        endcase

        // master clear: core back to defaults, programmed parameters survive
        if (clear_hold)
        begin
            st_next.phase            = PH_WAIT;                // RL1
            st_next.wait_cnt         = STRAP_WAIT;
            st_next.cfg.mem_en       = 1'b0;
            st_next.cfg.crlf         = 1'b0;
            st_next.cfg.standby      = 1'b0;
            st_next.cfg.bus_plus_req = 1'b0;
            st_next.cfg.proto        = PROTO_NONE;
            st_next.cfg.baud_rate    = 32'h00000000;
            st_next.cfg.straps       = 3'h0;
        end

        // pin outputs, registered from the new configuration
        st_next.supply_sel = (st_next.cfg.proto == PROTO_VPW) ^ st_next.cfg.supply_pol;           // RL9
        st_next.bus_plus   = st_next.cfg.bus_plus_req && !st_next.cfg.standby;                    // RL10
        st_next.bus_minus  = st_next.cfg.bus_plus_req && !st_next.cfg.standby &&
                             (st_next.cfg.proto == PROTO_PWM);                                    // RL11
        st_next.osc_en     = !st_next.cfg.standby;                                                // RL15
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= ST_RESET;
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign awready               = st_reg.awready;
    assign wready                = st_reg.wready;
    assign bvalid                = st_reg.bvalid;
    assign bresp                 = st_reg.bresp;
    assign arready               = st_reg.arready;
    assign rvalid                = st_reg.rvalid;
    assign rresp                 = st_reg.rresp;
    assign rdata                 = st_reg.rdata;
    assign bus_supply_select_out = st_reg.supply_sel;
    assign bus_plus_drive_out    = st_reg.bus_plus;
    assign bus_minus_drive_out   = st_reg.bus_minus;
    assign osc_enable_out        = st_reg.osc_en;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic mem_on_wr;
    logic lf_off_wr;
    assign mem_on_wr = wr_fire && (st_reg.awaddr_q == ADDR_CTRL) && st_reg.wstrb_q[0] &&
                       st_reg.wdata_q[CTRL_MEM_ON] && (st_reg.phase == PH_RUN) && !clear_hold;
    assign lf_off_wr = wr_fire && (st_reg.awaddr_q == ADDR_CTRL) && st_reg.wstrb_q[0] &&
                       st_reg.wdata_q[CTRL_LF_OFF] && !st_reg.wdata_q[CTRL_LF_ON] &&
                       (st_reg.phase == PH_RUN) && !clear_hold;

    property p_clear_reset;
        !pins_s[PIN_CLEAR] [*8] ##1 (!pins_s[PIN_CLEAR] && st_reg.clear_cnt == CLEAR_CNT_MAX)
            |=> st_reg.phase == PH_WAIT && !bus_plus_drive_out && osc_enable_out;
    endproperty
    a_clear_reset: assert property (p_clear_reset) else $error("clear did not reset core"); // RL1

    property p_clear_short;
        pins_s[PIN_CLEAR] ##1 (!pins_s[PIN_CLEAR] [*8]) |-> !clear_hold;
    endproperty
    a_clear_short: assert property (p_clear_short) else $error("short clear pulse reset core"); // RL1

    property p_mem_strap;
        st_reg.phase == PH_LOAD && !clear_hold |=> st_reg.cfg.mem_en == $past(pins_s[PIN_MEM]);
    endproperty
    a_mem_strap: assert property (p_mem_strap) else $error("memory default not from strap"); // RL2

    property p_mem_cmd;
        mem_on_wr |=> st_reg.cfg.mem_en ##1 status_word[0];
    endproperty
    a_mem_cmd: assert property (p_mem_cmd) else $error("memory on command ignored"); // RL3

    property p_baud_high;
        st_reg.phase == PH_LOAD && !clear_hold && pins_s[PIN_BAUD] && st_reg.cfg.baud_param == 32'h00000000
            |=> st_reg.cfg.baud_rate == BAUD_HIGH;
    endproperty
    a_baud_high: assert property (p_baud_high) else $error("high baud strap not 38400"); // RL4

    property p_baud_low;
        st_reg.phase == PH_LOAD && !clear_hold && !pins_s[PIN_BAUD] |=> st_reg.cfg.baud_rate == BAUD_LOW;
    endproperty
    a_baud_low: assert property (p_baud_low) else $error("low baud strap not 9600"); // RL5

    property p_lf_strap;
        st_reg.phase == PH_LOAD && !clear_hold |=> st_reg.cfg.crlf == $past(pins_s[PIN_LF]);
    endproperty
    a_lf_strap: assert property (p_lf_strap) else $error("line ending not from strap"); // RL6 RL7

    property p_lf_cmd;
        lf_off_wr |=> !st_reg.cfg.crlf;
    endproperty
    a_lf_cmd: assert property (p_lf_cmd) else $error("linefeed off command ignored"); // RL8

    property p_supply;
        ##1 1'b1 |-> bus_supply_select_out == ((st_reg.cfg.proto == PROTO_VPW) ^ st_reg.cfg.supply_pol);
    endproperty
    a_supply: assert property (p_supply) else $error("supply select wrong level"); // RL9

    property p_plus;
        bus_plus_drive_out |-> st_reg.cfg.bus_plus_req && !st_reg.cfg.standby;
    endproperty
    a_plus: assert property (p_plus) else $error("bus plus driven without request"); // RL10

    property p_minus;
        bus_minus_drive_out |-> st_reg.cfg.proto == PROTO_PWM && bus_plus_drive_out;
    endproperty
    a_minus: assert property (p_minus) else $error("bus minus driven outside pulse-width"); // RL11

    property p_rx_pol;
        // status shows the raw pins two samples late, after the synchroniser has left its reset levels
        ##3 1'b1 |-> status_word[3] == $past(variable_pulse_rx_in, 2) &&
            status_word[4] == !$past(kline_rx_in_n, 2) &&
            status_word[5] == !$past(pulse_width_rx_in_n, 2);
    endproperty
    a_rx_pol: assert property (p_rx_pol) else $error("receive polarity wrong"); // RL12 RL13 RL14

    property p_osc;
        osc_enable_out != st_reg.cfg.standby;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator running in standby"); // RL15

    property p_strap_latch;
        $rose(aresetn) |-> st_reg.phase == PH_WAIT ##[1:3] st_reg.phase == PH_LOAD;
    endproperty
    a_strap_latch: assert property (p_strap_latch) else $error("straps not latched after reset"); // RL16

    c_write:   cover property (wr_fire ##[1:4] (bvalid && bready));
    c_read:    cover property ((arvalid && arready) ##1 rvalid);
    c_clear:   cover property ($rose(clear_hold));
    c_standby: cover property ($fell(osc_enable_out) ##[1:20] $rose(osc_enable_out));

endmodule : dbp_bridge

// File: verilog/dbp_pkg.sv
// constants, types and reset values shared by the diagnostic bridge pin logic
package dbp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int           CLK_PERIOD_NS = 50;
    localparam int           CLEAR_MIN_NS  = 2000;
    localparam int           CLEAR_CYCLES  = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]   CLEAR_CNT_MAX = 8'(CLEAR_CYCLES);
    localparam int           SYNC_STAGES   = 2;
    localparam logic [1:0]   STRAP_WAIT    = 2'(SYNC_STAGES);

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses)
    localparam logic [4:0]   ADDR_CTRL       = 5'h00;
    localparam logic [4:0]   ADDR_PARAM      = 5'h04;
    localparam logic [4:0]   ADDR_BAUD_PARAM = 5'h08;
    localparam logic [4:0]   ADDR_STATUS     = 5'h0C;
    localparam logic [4:0]   ADDR_BAUD_RATE  = 5'h10;

    // control register bits, the four command bits write one to fire
    localparam int           CTRL_MEM_ON  = 0;
    localparam int           CTRL_MEM_OFF = 1;
    localparam int           CTRL_LF_ON   = 2;
    localparam int           CTRL_LF_OFF  = 3;
    localparam int           CTRL_PROTO   = 8;
    localparam int           CTRL_BUS_PLS = 12;
    localparam int           CTRL_STANDBY = 16;

    // serial rates in bits per second
    localparam logic [31:0]  BAUD_LOW  = 32'h00002580;
    localparam logic [31:0]  BAUD_HIGH = 32'h00009600;

    localparam logic [1:0]   RESP_OKAY   = 2'h0;
    localparam logic [1:0]   RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // pin vector layout and idle levels
    localparam int           PIN_CLEAR = 0;
    localparam int           PIN_MEM   = 1;
    localparam int           PIN_BAUD  = 2;
    localparam int           PIN_LF    = 3;
    localparam int           PIN_VPW   = 4;
    localparam int           PIN_KLINE = 5;
    localparam int           PIN_PWM   = 6;
    localparam int           PIN_COUNT = 7;
    localparam logic [6:0]   PIN_IDLE  = 7'h61;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        PROTO_NONE  = 2'h0,
        PROTO_VPW   = 2'h1,
        PROTO_PWM   = 2'h2,
        PROTO_KLINE = 2'h3
    } dbp_proto_t;

    typedef enum logic [2:0] {
        PH_WAIT = 3'h1,
        PH_LOAD = 3'h2,
        PH_RUN  = 3'h4
    } dbp_phase_t;

    typedef struct packed {
        logic [PIN_COUNT-1:0] meta;
        logic [PIN_COUNT-1:0] sync;
    } dbp_sync_t;

    typedef struct packed {
        logic        mem_en;
        logic        crlf;
        logic        standby;
        logic        bus_plus_req;
        dbp_proto_t  proto;
        logic        supply_pol;
        logic [31:0] baud_param;
        logic [31:0] baud_rate;
        logic [2:0]  straps;
    } dbp_cfg_t;

    typedef struct packed {
        dbp_phase_t  phase;
        logic [1:0]  wait_cnt;
        logic [7:0]  clear_cnt;
        dbp_cfg_t    cfg;
        logic        aw_have;
        logic [4:0]  awaddr_q;
        logic        w_have;
        logic [31:0] wdata_q;
        logic [3:0]  wstrb_q;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        supply_sel;
        logic        bus_plus;
        logic        bus_minus;
        logic        osc_en;
    } dbp_state_t;

    localparam dbp_state_t ST_RESET = '{phase: PH_WAIT, wait_cnt: STRAP_WAIT, awready: 1'b1, wready: 1'b1,
                                        arready: 1'b1, osc_en: 1'b1, cfg: '0, default: '0};

    // byte-lane merge for register writes
    function automatic logic [31:0] dbp_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction : dbp_merge

endpackage : dbp_pkg

// File: verilog/dbp_sync.sv
// two-stage synchroniser for the asynchronous strap, clear and receive pins
`timescale 1ns/100ps
module dbp_sync
    import dbp_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [PIN_COUNT-1:0] pins,
    output logic      [PIN_COUNT-1:0] pins_sync
);

    dbp_sync_t st_reg;
    dbp_sync_t st_next;

    ////////////////////////////////////////////////////////////////////////////////
    // first stage is read only by the second stage
    always_comb
    begin
        st_next      = st_reg;
        st_next.meta = pins;
        st_next.sync = st_reg.meta;
    end

    // idle levels during reset so nothing looks active
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= '{meta: PIN_IDLE, sync: PIN_IDLE};
        else
            st_reg <= st_next;
    end

    assign pins_sync = st_reg.sync;

endmodule : dbp_sync
